//--- inc/nalu_pkg.sv
// Purpose: Shared constants and types for the nibble ALU and skip logic
// Assumes: Four-bit data path, one instruction per enable
// Notes: Operation codes are internal to the decoder interface
package nalu_pkg;
    localparam int NIB_W = 4;
    localparam int IDX_W = 2;
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic CARRY_RST = 1'b0;
    localparam int OP_W = 4;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD_MEM = 4'h1,
        OP_ADD_CARRY = 4'h2,
        OP_ADD_IMM = 4'h3,
        OP_AND_MEM = 4'h4,
        OP_OR_MEM = 4'h5,
        OP_SET_CARRY = 4'h6,
        OP_CLR_CARRY = 4'h7,
        OP_TEST_CARRY = 4'h8,
        OP_COMPLEMENT = 4'h9,
        OP_ROTATE = 4'ha,
        OP_SET_BIT = 4'hb,
        OP_CLR_BIT = 4'hc,
        OP_TEST_BIT = 4'hd,
        OP_CMP_MEM = 4'he,
        OP_CMP_IMM = 4'hf
    } alu_op_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_SKIP = 2'b10
    } seq_state_t;
endpackage : nalu_pkg

//--- inc/alu_if.sv
// Purpose: Carries operands and results between top and compute unit
// Assumes: Purely combinational path
// Notes: None
interface alu_if;
    import nalu_pkg::*;
    alu_op_t op;
    logic [3:0] acc;
    logic [3:0] mem;
    logic [3:0] imm;
    logic carry;
    logic [3:0] acc_res;
    logic carry_res;
    logic [3:0] mem_res;
    logic acc_we;
    logic carry_we;
    logic mem_we;
    logic skip;
    modport top (output op, acc, mem, imm, carry,
        input acc_res, carry_res, mem_res, acc_we, carry_we, mem_we, skip);
    modport unit (input op, acc, mem, imm, carry,
        output acc_res, carry_res, mem_res, acc_we, carry_we, mem_we, skip);
endinterface : alu_if

//--- rtl/alu_compute.sv
// Purpose: Combinational result, write enables and skip decision
// Assumes: Operands stable for the whole instruction cycle
// Notes: Overflow is the carry out of bit 3
module alu_compute
    import nalu_pkg::*;
(
    alu_if.unit bus
);
    logic [4:0] sum;
    logic [3:0] bit_mask;
    always_comb begin
        bit_mask = 4'h1 << bus.imm[1:0];
        sum = 5'h00;
        bus.acc_res = bus.acc;
        bus.carry_res = bus.carry;
        bus.mem_res = bus.mem;
        bus.acc_we = 1'b0;
        bus.carry_we = 1'b0;
        bus.mem_we = 1'b0;
        bus.skip = 1'b0;
        unique case (bus.op)
            OP_NOP: begin
            end
            OP_ADD_MEM: begin
                sum = {1'b0, bus.acc} + {1'b0, bus.mem};
                bus.acc_res = sum[3:0];
                bus.acc_we = 1'b1;
            end
            OP_ADD_CARRY: begin
                sum = {1'b0, bus.acc} + {1'b0, bus.mem} + {4'h0, bus.carry};
                bus.acc_res = sum[3:0];
                bus.carry_res = sum[4];
                bus.acc_we = 1'b1;
                bus.carry_we = 1'b1;
            end
            OP_ADD_IMM: begin
                sum = {1'b0, bus.acc} + {1'b0, bus.imm};
                bus.acc_res = sum[3:0];
                bus.acc_we = 1'b1;
                bus.skip = ~sum[4];
            end
            OP_AND_MEM: begin
                bus.acc_res = bus.acc & bus.mem;
                bus.acc_we = 1'b1;
            end
            OP_OR_MEM: begin
                bus.acc_res = bus.acc | bus.mem;
                bus.acc_we = 1'b1;
            end
            OP_SET_CARRY: begin
                bus.carry_res = 1'b1;
                bus.carry_we = 1'b1;
            end
            OP_CLR_CARRY: begin
                bus.carry_res = 1'b0;
                bus.carry_we = 1'b1;
            end
            OP_TEST_CARRY: begin
                bus.skip = ~bus.carry;
            end
            OP_COMPLEMENT: begin
                bus.acc_res = ~bus.acc;
                bus.acc_we = 1'b1;
            end
            OP_ROTATE: begin
                bus.acc_res = {bus.carry, bus.acc[3:1]};
                bus.carry_res = bus.acc[0];
                bus.acc_we = 1'b1;
                bus.carry_we = 1'b1;
            end
            OP_SET_BIT: begin
                bus.mem_res = bus.mem | bit_mask;
                bus.mem_we = 1'b1;
            end
            OP_CLR_BIT: begin
                bus.mem_res = bus.mem & ~bit_mask;
                bus.mem_we = 1'b1;
            end
            OP_TEST_BIT: begin
                bus.skip = ~|(bus.mem & bit_mask);
            end
            OP_CMP_MEM: begin
                bus.skip = (bus.acc == bus.mem);
            end
            OP_CMP_IMM: begin
                bus.skip = (bus.acc == bus.imm);
            end
        endcase
    end
endmodule : alu_compute

//--- rtl/skip_seq.sv
// Purpose: Holds the pending skip across one instruction
// Assumes: step marks one instruction slot
// Notes: A skipped slot never raises a new skip
module skip_seq
    import nalu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step,
    input wire logic skip_req,
    output logic squash
);
    seq_state_t state;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN;
        end else if (step) begin
            unique case (state)
                ST_RUN: state <= skip_req ? ST_SKIP : ST_RUN;
                ST_SKIP: state <= ST_RUN;
                // Two-bit one-hot can hold an illegal code; recover to run
                default: state <= ST_RUN;
            endcase
        end
    end
    assign squash = (state == ST_SKIP);
endmodule : skip_seq

//--- rtl/nibble_alu_skip_logic.sv
// Purpose: Accumulator, carry and pointed-memory datapath with skip tests
// Assumes: Memory read data valid in the cycle of OP_VALID
// Notes: One instruction per OP_VALID pulse; results land at that edge
module nibble_alu_skip_logic
    import nalu_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic OP_VALID,
    input wire logic [OP_W-1:0] OP_CODE,
    input wire logic [NIB_W-1:0] IMMEDIATE,
    input wire logic [NIB_W-1:0] MEM_RDATA,
    output logic [NIB_W-1:0] ACCUMULATOR,
    output logic CARRY_FLAG,
    output logic MEM_WE,
    output logic [NIB_W-1:0] MEM_WDATA,
    output logic SKIP_PENDING,
    output logic SQUASHED
);
    alu_if bus();
    logic squash;
    logic live;
    assign live = OP_VALID && !squash;
    // Squashed slot is fed as no-op so nothing in the unit can write
    assign bus.op = live ? alu_op_t'(OP_CODE) : OP_NOP;
    assign bus.acc = ACCUMULATOR;
    assign bus.carry = CARRY_FLAG;
    assign bus.mem = MEM_RDATA;
    assign bus.imm = IMMEDIATE;

    alu_compute u_compute (
        .bus(bus.unit)
    );

    skip_seq u_skip (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .step(OP_VALID),
        .skip_req(bus.skip),
        .squash(squash)
    );

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ACCUMULATOR <= ACC_RST;
        end else if (bus.acc_we) begin
            ACCUMULATOR <= bus.acc_res;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            CARRY_FLAG <= CARRY_RST;
        end else if (bus.carry_we) begin
            CARRY_FLAG <= bus.carry_res;
        end
    end

    // Write strobe is registered, so memory sees it one cycle later;
    // the pointer must not move in that cycle.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            MEM_WE <= 1'b0;
            MEM_WDATA <= 4'h0;
        end else begin
            MEM_WE <= bus.mem_we;
            if (bus.mem_we) begin
                MEM_WDATA <= bus.mem_res;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            SKIP_PENDING <= 1'b0;
            SQUASHED <= 1'b0;
        end else if (OP_VALID) begin
            SKIP_PENDING <= bus.skip;
            SQUASHED <= squash;
        end
    end

    chk_skip_nop_acc: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (OP_VALID && squash) |=> $stable(ACCUMULATOR))
        else $error("accumulator changed in skipped slot");
    chk_skip_nop_mem: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (OP_VALID && squash) |=> !MEM_WE)
        else $error("memory written in skipped slot");
    chk_adc_carry: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_ADD_CARRY) |=>
        ({CARRY_FLAG, ACCUMULATOR} == $past(ACCUMULATOR) + $past(MEM_RDATA)
        + $past(CARRY_FLAG)))
        else $error("add with carry result wrong");
    chk_add_keep_cy: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && (OP_CODE == OP_ADD_MEM || OP_CODE == OP_ADD_IMM)) |=>
        $stable(CARRY_FLAG))
        else $error("carry changed by plain add");
    chk_imm_skip: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_ADD_IMM) |=>
        (SKIP_PENDING == ({1'b0, $past(ACCUMULATOR)} + {1'b0, $past(IMMEDIATE)}
        < 5'h10)))
        else $error("immediate add skip wrong");
    chk_rotate_cy: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_ROTATE) |=>
        (CARRY_FLAG == $past(ACCUMULATOR[0]) &&
        ACCUMULATOR[3] == $past(CARRY_FLAG)))
        else $error("rotate through carry wrong");
    chk_bit_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_SET_BIT) |=>
        (MEM_WE && MEM_WDATA[$past(IMMEDIATE[1:0])]))
        else $error("bit set not written");
    chk_cmp_mem: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_CMP_MEM) |=>
        (SKIP_PENDING == ($past(ACCUMULATOR) == $past(MEM_RDATA))))
        else $error("memory compare skip wrong");
    chk_carry_test: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_TEST_CARRY) |=>
        (SKIP_PENDING == !$past(CARRY_FLAG)))
        else $error("carry test skip wrong");
    chk_skip_once: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (OP_VALID && squash) |=> !SKIP_PENDING)
        else $error("skipped slot raised a skip");
    chk_imm_sum: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_ADD_IMM) |=>
        (ACCUMULATOR == 4'($past(ACCUMULATOR) + $past(IMMEDIATE))))
        else $error("immediate add sum wrong");
    chk_and_mem: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_AND_MEM) |=>
        (ACCUMULATOR == ($past(ACCUMULATOR) & $past(MEM_RDATA))))
        else $error("and result wrong");
    chk_or_mem: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_OR_MEM) |=>
        (ACCUMULATOR == ($past(ACCUMULATOR) | $past(MEM_RDATA))))
        else $error("or result wrong");
    chk_set_carry: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_SET_CARRY) |=> CARRY_FLAG)
        else $error("carry not set");
    chk_clr_carry: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_CLR_CARRY) |=> !CARRY_FLAG)
        else $error("carry not cleared");
    chk_complement: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_COMPLEMENT) |=>
        (ACCUMULATOR == ~$past(ACCUMULATOR)))
        else $error("complement wrong");
    chk_bit_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_CLR_BIT) |=>
        (MEM_WE && !MEM_WDATA[$past(IMMEDIATE[1:0])]))
        else $error("bit clear not written");
    chk_bit_test: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_TEST_BIT) |=>
        (SKIP_PENDING == !$past(MEM_RDATA[IMMEDIATE[1:0]])))
        else $error("bit test skip wrong");
    chk_cmp_imm: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (live && OP_CODE == OP_CMP_IMM) |=>
        (SKIP_PENDING == ($past(ACCUMULATOR) == $past(IMMEDIATE))))
        else $error("immediate compare skip wrong");
endmodule : nibble_alu_skip_logic

//--- dv/mem_partner.sv
// Purpose: Pointed memory nibble seen by the datapath
// Assumes: Data pointer fixed, so one nibble stands for memory
// Notes: Bench preloads through load; writes land on MEM_WE
module mem_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [3:0] load_val,
    input wire logic we,
    input wire logic [3:0] wdata,
    output logic [3:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] mem;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem <= 4'h0;
        end else if (load) begin
            mem <= load_val;
        end else if (we) begin
            mem <= wdata;
        end
    end
    // Always driven, so no stale value hazard
    assign rdata = mem;
endmodule : mem_partner

//--- dv/testbench.sv
// Purpose: Self-checking bench for the nibble datapath
// Assumes: One slot per run call, then one idle cycle
// Notes: Idle cycle lets the memory write land before the next read
module testbench;
    import nalu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, reset_n = 0, op_valid = 0, load = 0, mem_we;
    logic [3:0] op_code = 4'h0, immediate = 4'h0, load_val = 4'h0;
    logic [3:0] mem_rdata, accumulator, mem_wdata;
    logic carry_flag, skip_pending, squashed;
    logic [3:0] e_acc = 0, e_mem = 0;
    logic e_cy = 0, e_skip = 0, e_sq = 0;
    int failures = 0, compares = 0, cycles = 0;
    always #10 clock = ~clock;
    nibble_alu_skip_logic nibble_alu_skip_logic_i (.CLOCK(clock),
        .RESET_N(reset_n), .OP_VALID(op_valid), .OP_CODE(op_code),
        .IMMEDIATE(immediate), .MEM_RDATA(mem_rdata),
        .ACCUMULATOR(accumulator), .CARRY_FLAG(carry_flag),
        .MEM_WE(mem_we), .MEM_WDATA(mem_wdata),
        .SKIP_PENDING(skip_pending), .SQUASHED(squashed));
    mem_partner mem_partner_i (.clk(clock), .rst_n(reset_n), .load(load),
        .load_val(load_val), .we(mem_we), .wdata(mem_wdata),
        .rdata(mem_rdata));
    task automatic chk(input string n, input logic [3:0] e,
        input logic [3:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic run(input alu_op_t op, input logic [3:0] imm);
        logic [4:0] s;
        logic sk, we;
        logic [3:0] wd;
        sk = 0;
        we = 0;
        wd = e_mem;
        s = 5'h0;
        // Skipped slot changes nothing
        if (!e_skip) case (op)
            OP_ADD_MEM: begin s = e_acc + e_mem; e_acc = s[3:0]; end
            OP_ADD_CARRY: {e_cy, e_acc} = e_acc + e_mem + e_cy;
            OP_ADD_IMM: begin s = e_acc + imm; e_acc = s[3:0];
                sk = !s[4]; end
            OP_AND_MEM: e_acc = e_acc & e_mem;
            OP_OR_MEM: e_acc = e_acc | e_mem;
            OP_SET_CARRY: e_cy = 1;
            OP_CLR_CARRY: e_cy = 0;
            OP_TEST_CARRY: sk = !e_cy;
            OP_COMPLEMENT: e_acc = ~e_acc;
            OP_ROTATE: {e_acc, e_cy} = {e_cy, e_acc};
            OP_SET_BIT: begin we = 1; wd[imm[1:0]] = 1; end
            OP_CLR_BIT: begin we = 1; wd[imm[1:0]] = 0; end
            OP_TEST_BIT: sk = !e_mem[imm[1:0]];
            OP_CMP_MEM: sk = e_acc == e_mem;
            OP_CMP_IMM: sk = e_acc == imm;
            default: ;
        endcase
        e_sq = e_skip;
        e_skip = sk;
        op_valid = 1;
        op_code = op;
        immediate = imm;
        @(negedge clock);
        op_valid = 0;
        chk("acc", e_acc, accumulator);
        chk("carry", e_cy, carry_flag);
        chk("skip", e_skip, skip_pending);
        chk("squash", e_sq, squashed);
        chk("we", we, mem_we);
        if (we) chk("wdata", wd, mem_wdata);
        e_mem = wd;
        @(negedge clock);
        chk("we_end", 0, mem_we);
    endtask : run
    task automatic setm(input logic [3:0] v);
        load = 1;
        load_val = v;
        e_mem = v;
        @(negedge clock);
        load = 0;
    endtask : setm
    task automatic seta(input logic [3:0] v);
        setm(4'h0);
        run(OP_AND_MEM, 4'h0);
        setm(v);
        run(OP_OR_MEM, 4'h0);
    endtask : seta
    task automatic t_add;
        seta(4'h7);
        run(OP_SET_CARRY, 4'h0);
        setm(4'h9);
        run(OP_ADD_MEM, 4'h0);
        run(OP_ADD_CARRY, 4'h0);
        setm(4'hf);
        run(OP_ADD_CARRY, 4'h0);
        $display("test add done");
    endtask : t_add
    task automatic t_imm;
        seta(4'he);
        run(OP_ADD_IMM, 4'h1);
        run(OP_COMPLEMENT, 4'h0);
        run(OP_ADD_IMM, 4'h1);
        run(OP_COMPLEMENT, 4'h0);
        $display("test immediate done");
    endtask : t_imm
    task automatic t_logic;
        seta(4'hc);
        setm(4'ha);
        run(OP_AND_MEM, 4'h0);
        run(OP_OR_MEM, 4'h0);
        run(OP_COMPLEMENT, 4'h0);
        $display("test logic done");
    endtask : t_logic
    task automatic t_carry;
        run(OP_CLR_CARRY, 4'h0);
        run(OP_TEST_CARRY, 4'h0);
        run(OP_SET_CARRY, 4'h0);
        run(OP_SET_CARRY, 4'h0);
        run(OP_TEST_CARRY, 4'h0);
        seta(4'h6);
        run(OP_ROTATE, 4'h0);
        run(OP_ROTATE, 4'h0);
        $display("test carry done");
    endtask : t_carry
    task automatic t_bits;
        for (int j = 0; j < 4; j++) begin
            setm(4'hf);
            run(OP_CLR_BIT, 4'(j));
            run(OP_TEST_BIT, 4'(j));
            run(OP_SET_BIT, 4'(j));
            run(OP_SET_BIT, 4'(j));
            run(OP_TEST_BIT, 4'(j));
        end
        $display("test bits done");
    endtask : t_bits
    task automatic t_cmp;
        seta(4'h5);
        setm(4'h5);
        run(OP_CMP_MEM, 4'h0);
        run(OP_NOP, 4'h0);
        setm(4'h4);
        run(OP_CMP_MEM, 4'h0);
        run(OP_CMP_IMM, 4'h5);
        run(OP_CMP_IMM, 4'h5);
        run(OP_CMP_IMM, 4'h4);
        $display("test compare done");
    endtask : t_cmp
    task automatic t_reset;
        seta(4'h9);
        run(OP_SET_CARRY, 4'h0);
        run(OP_CMP_IMM, 4'h9);
        reset_n = 0;
        repeat (2) @(negedge clock);
        chk("rst_acc", ACC_RST, accumulator);
        chk("rst_carry", CARRY_RST, carry_flag);
        chk("rst_skip", 0, skip_pending);
        reset_n = 1;
        {e_acc, e_mem, e_cy, e_skip, e_sq} = 0;
        run(OP_ADD_IMM, 4'h3);
        $display("test reset done");
    endtask : t_reset
    task automatic results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    always @(posedge clock) begin
        cycles++;
        if (cycles >= 5000) begin
            failures++;
            results();
        end
    end
    initial begin
        repeat (16) @(negedge clock);
        reset_n = 1;
        @(negedge clock);
        t_add();
        t_imm();
        t_logic();
        t_carry();
        t_bits();
        t_cmp();
        t_reset();
        results();
    end
endmodule : testbench
